/* File: rtl/biu_pkg.sv */
// Behaviour
// - Four transfer kinds exist: normal read, fast read, early write, late write.
// - Kind follows direction, address region and the programmed read and write modes.
// - Basic normal read takes two clocks; basic fast read takes one clock.
// - After reset reads use the normal read kind.
// - Basic late write takes two clocks; basic early write takes three clocks.
// - After reset writes use the early write kind.
// - Wait cycles follow directly after the address is placed on the bus.
// - Hold cycles close the bus cycle and keep write data driven.
// - Configured wait and hold counts shape the strobes of zone 0 accesses only.
// - Write mode register sits at F900 hex, byte wide, read/write, resets to 07.
// - Bit 0 low selects late write, high selects early write.
// - Fast read enable bit in zone 0 timing register selects fast reads.
// - Three-bit wait field adds zero to seven waits; ignored under fast read.
// - Two-bit hold field adds zero to three holds; ignored under fast read.
package biu_pkg;

    // ==========================================================
    // Register map (byte addresses on the register bus)
    localparam logic [15:0] WCC_ADDR = 16'hF900;
    localparam logic [15:0] ZTC_ADDR = 16'hF904;
    localparam logic [15:0] STATUS_ADDR = 16'hF908;
    localparam logic [7:0] WCC_RESET = 8'h07;
    localparam logic [7:0] WCC_WMASK = 8'h07;
    localparam logic [15:0] ZTC_RESET = 16'h069F;
    localparam logic [15:0] ZTC_WMASK = 16'h0EFF;

    // ==========================================================
    // Field positions
    localparam int EARLY_BIT = 0;
    localparam int WAIT_LSB = 0;
    localparam int HOLD_LSB = 3;
    localparam int FRE_BIT = 11;

    // ==========================================================
    // Address regions
    localparam logic [15:0] FLASH_TOP = 16'hBFFF;
    localparam logic [15:0] RAM_BASE = 16'hE000;
    localparam logic [15:0] RAM_TOP = 16'hE7FF;
    localparam logic [15:0] PERIPH_BASE = 16'hF000;

    // ==========================================================
    // Cycle timing in clocks; strobe length is base cycle minus address cycle
    localparam logic [3:0] PERIPH_WAITS = 4'h1;
    localparam logic [3:0] NORMAL_STROBE_LEN = 4'h1;
    localparam logic [3:0] LATE_STROBE_LEN = 4'h1;
    localparam logic [3:0] EARLY_STROBE_LEN = 4'h2;

    typedef enum logic [1:0] {
        REGION_FLASH,
        REGION_RAM,
        REGION_PERIPH,
        REGION_OTHER
    } region_t;

    typedef enum logic [1:0] {
        KIND_NORMAL_READ,
        KIND_FAST_READ,
        KIND_EARLY_WRITE,
        KIND_LATE_WRITE
    } cycle_kind_t;

    // Region decode, shared by kind selection and wait selection
    function automatic region_t region_of(input logic [15:0] addr);
        region_t r;
        r = REGION_OTHER;
        if (addr <= FLASH_TOP) begin
            r = REGION_FLASH;
        end else if (addr >= RAM_BASE && addr <= RAM_TOP) begin
            r = REGION_RAM;
        end else if (addr >= PERIPH_BASE) begin
            r = REGION_PERIPH;
        end
        return r;
    endfunction

endpackage

/* File: rtl/phase_counter.sv */
`timescale 1ns/1ps
module phase_counter (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_load,
    input wire logic [3:0] i_value,
    output logic o_zero
);
    logic [3:0] count;

    // ==========================================================
    // Down counter for phase length; load wins over counting
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            count <= 4'h0;
        end else if (i_load) begin
            count <= i_value;
        end else if (count != 4'h0) begin
            count <= count - 4'h1;
        end
    end

    assign o_zero = (count == 4'h0);
endmodule

/* File: rtl/biu_regs.sv */
`timescale 1ns/1ps
module biu_regs (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [15:0] i_wb_adr,
    input wire logic [31:0] i_wb_dat,
    input wire logic [3:0] i_wb_sel,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    input wire logic [7:0] i_status,
    output logic [7:0] o_write_cycle_config,
    output logic [15:0] o_zone0_timing_config
);
    import biu_pkg::*;

    // ==========================================================
    // Decode; writes land on the edge where the master sees ack
    wire access = i_wb_cyc && i_wb_stb;
    wire commit = access && i_wb_we && o_wb_ack;
    wire hit_wcc = (i_wb_adr == WCC_ADDR);
    wire hit_ztc = (i_wb_adr == ZTC_ADDR);
    wire hit_status = (i_wb_adr == STATUS_ADDR);
    wire [15:0] ztc_lanes = {{8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}} & ZTC_WMASK;
    // Reserved bits never take write data, so they keep reset value
    wire [7:0] next_wcc = (o_write_cycle_config & ~(WCC_WMASK & {8{i_wb_sel[0]}}))
                        | (i_wb_dat[7:0] & WCC_WMASK & {8{i_wb_sel[0]}});
    wire [15:0] next_ztc = (o_zone0_timing_config & ~ztc_lanes) | (i_wb_dat[15:0] & ztc_lanes);
    // Unmapped addresses answer with zero and drop writes
    wire [31:0] rd_mux = hit_wcc ? {24'h000000, o_write_cycle_config}
                       : hit_ztc ? {16'h0000, o_zone0_timing_config}
                       : hit_status ? {24'h000000, i_status} : 32'h00000000;

    // ==========================================================
    // Single-wait ack, dropped the cycle after it is given
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h00000000;
        end else begin
            o_wb_ack <= access && !o_wb_ack;
            if (access && !o_wb_ack) begin
                o_wb_dat <= rd_mux;
            end
        end
    end

    // Configuration storage
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_write_cycle_config <= WCC_RESET;
            o_zone0_timing_config <= ZTC_RESET;
        end else begin
            if (commit && hit_wcc) begin
                o_write_cycle_config <= next_wcc;
            end
            if (commit && hit_ztc) begin
                o_zone0_timing_config <= next_ztc;
            end
        end
    end
endmodule

/* File: rtl/bus_interface_unit.sv */
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ps
module bus_interface_unit (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // Register bus
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [15:0] i_wb_adr,
    input wire logic [31:0] i_wb_dat,
    input wire logic [3:0] i_wb_sel,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    // CPU request side
    input wire logic i_cpu_req,
    input wire logic i_cpu_we,
    input wire logic [15:0] i_cpu_addr,
    input wire logic [15:0] i_cpu_wdata,
    output logic o_cpu_busy,
    output logic o_cpu_done,
    output logic [15:0] o_cpu_rdata,
    output biu_pkg::cycle_kind_t o_cycle_kind,
    // Core bus toward memories and modules
    output logic [15:0] o_mod_addr,
    output logic o_mod_addr_valid,
    output logic [15:0] o_mod_wdata,
    output logic o_mod_data_en,
    output logic o_mod_rd,
    output logic o_mod_wr,
    input wire logic [15:0] i_mod_rdata
);
    import biu_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_WAIT,
        ST_STROBE,
        ST_HOLD
    } state_t;

    state_t state;
    state_t next_state;
    logic [7:0] write_cycle_config;
    logic [15:0] zone0_timing_config;
    logic [3:0] wait_count;
    logic [3:0] hold_count;
    logic [3:0] strobe_len;
    logic phase_zero;
    logic cnt_load;
    logic [3:0] cnt_value;
    logic [7:0] status;

    // ==========================================================
    // Configuration registers behind the register bus
    biu_regs u_regs (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_wb_cyc(i_wb_cyc),
        .i_wb_stb(i_wb_stb),
        .i_wb_we(i_wb_we),
        .i_wb_adr(i_wb_adr),
        .i_wb_dat(i_wb_dat),
        .i_wb_sel(i_wb_sel),
        .o_wb_dat(o_wb_dat),
        .o_wb_ack(o_wb_ack),
        .i_status(status),
        .o_write_cycle_config(write_cycle_config),
        .o_zone0_timing_config(zone0_timing_config)
    );

    // ==========================================================
    // Programmed modes
    // Reset values leave the fast read bit low and bit 0 high, so the
    // device starts with normal reads and early writes
    wire early_write_select = write_cycle_config[EARLY_BIT];
    wire fast_read_enable = zone0_timing_config[FRE_BIT];
    wire [3:0] zone_waits = {1'b0, zone0_timing_config[WAIT_LSB +: 3]};
    wire [3:0] zone_holds = {2'b00, zone0_timing_config[HOLD_LSB +: 2]};

    // ==========================================================
    // Cycle kind decode for the request offered now
    // Fast reads exist only in zone 0; every other region reads normally
    wire region_t req_region = region_of(i_cpu_addr);
    wire req_in_zone0 = (req_region == REGION_FLASH);
    wire req_fast = !i_cpu_we && req_in_zone0 && fast_read_enable;
    wire cycle_kind_t req_kind = i_cpu_we
        ? (early_write_select ? KIND_EARLY_WRITE : KIND_LATE_WRITE)
        : (req_fast ? KIND_FAST_READ : KIND_NORMAL_READ);

    // Wait and hold counts; zone fields are ignored while fast read is on
    wire zone_fields_used = req_in_zone0 && !fast_read_enable;
    wire [3:0] req_waits = zone_fields_used ? zone_waits
                         : (req_region == REGION_PERIPH) ? PERIPH_WAITS : 4'h0;
    wire [3:0] req_holds = zone_fields_used ? zone_holds : 4'h0;
    // Early writes spend one extra clock with the write strobe raised
    wire [3:0] req_strobe = (req_kind == KIND_EARLY_WRITE) ? EARLY_STROBE_LEN
                          : (req_kind == KIND_LATE_WRITE) ? LATE_STROBE_LEN
                          : NORMAL_STROBE_LEN;

    // ==========================================================
    // Phase length counter
    phase_counter u_phase (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_load(cnt_load),
        .i_value(cnt_value),
        .o_zero(phase_zero)
    );

    // ==========================================================
    // Phase transitions
    wire take_req = (state == ST_IDLE) && i_cpu_req;
    wire is_fast = (o_cycle_kind == KIND_FAST_READ);
    wire is_write = (o_cycle_kind == KIND_EARLY_WRITE) || (o_cycle_kind == KIND_LATE_WRITE);
    wire addr_to_wait = (state == ST_ADDR) && !is_fast && (wait_count != 4'h0);
    wire addr_to_strobe = (state == ST_ADDR) && !is_fast && (wait_count == 4'h0);
    wire wait_to_strobe = (state == ST_WAIT) && phase_zero;
    wire strobe_end = (state == ST_STROBE) && phase_zero;
    wire strobe_to_hold = strobe_end && (hold_count != 4'h0);
    wire hold_end = (state == ST_HOLD) && phase_zero;
    // Last clock of the bus cycle, whatever kind it is
    wire cycle_last = ((state == ST_ADDR) && is_fast)
                    || (strobe_end && (hold_count == 4'h0)) || hold_end;
    // Read data is sampled where the read strobe ends
    wire capture_rd = ((state == ST_ADDR) && is_fast) || (strobe_end && !is_write);

    // Counter holds remaining clocks minus one for the entered phase
    assign cnt_load = addr_to_wait || addr_to_strobe || wait_to_strobe || strobe_to_hold;
    assign cnt_value = addr_to_wait ? wait_count - 4'h1
                     : strobe_to_hold ? hold_count - 4'h1
                     : strobe_len - 4'h1;

    // Next state selection
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (take_req) begin
                    next_state = ST_ADDR;
                end
            end
            ST_ADDR: begin
                if (is_fast) begin
                    next_state = ST_IDLE;
                end else if (addr_to_wait) begin
                    next_state = ST_WAIT;
                end else begin
                    next_state = ST_STROBE;
                end
            end
            ST_WAIT: begin
                if (wait_to_strobe) begin
                    next_state = ST_STROBE;
                end
            end
            ST_STROBE: begin
                if (strobe_to_hold) begin
                    next_state = ST_HOLD;
                end else if (strobe_end) begin
                    next_state = ST_IDLE;
                end
            end
            ST_HOLD: begin
                if (hold_end) begin
                    next_state = ST_IDLE;
                end
            end
        endcase
    end

    // ==========================================================
    // State register
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Request latch; address and data stay put for the whole cycle
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_mod_addr <= 16'h0000;
            o_mod_wdata <= 16'h0000;
            o_cycle_kind <= KIND_NORMAL_READ;
            wait_count <= 4'h0;
            hold_count <= 4'h0;
            strobe_len <= 4'h1;
        end else if (take_req) begin
            o_mod_addr <= i_cpu_addr;
            o_mod_wdata <= i_cpu_wdata;
            o_cycle_kind <= req_kind;
            wait_count <= req_waits;
            hold_count <= req_holds;
            strobe_len <= req_strobe;
        end
    end

    // Completion pulse one clock after the bus cycle; read data one clock after the read strobe
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_cpu_done <= 1'b0;
            o_cpu_rdata <= 16'h0000;
        end else begin
            o_cpu_done <= cycle_last;
            if (capture_rd) begin
                o_cpu_rdata <= i_mod_rdata;
            end
        end
    end

    // ==========================================================
    // Bus control outputs
    // Write data stays driven through the hold phase so slow targets
    // still see it after the write strobe drops
    assign o_cpu_busy = (state != ST_IDLE);
    assign o_mod_addr_valid = (state != ST_IDLE);
    assign o_mod_rd = !is_write && ((state == ST_STROBE) || ((state == ST_ADDR) && is_fast));
    assign o_mod_wr = is_write && (state == ST_STROBE);
    assign o_mod_data_en = is_write && ((state == ST_STROBE) || (state == ST_HOLD));

    // Status seen by software: busy flag and kind of the last cycle
    assign status = {5'b00000, o_cycle_kind, o_cpu_busy};
endmodule

/* File: tb/biu_chk.sv */
`timescale 1ns/1ps
module biu_chk (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic o_wb_ack,
    input wire logic o_cpu_busy,
    input wire logic o_cpu_done,
    input wire biu_pkg::cycle_kind_t o_cycle_kind,
    input wire logic [15:0] o_mod_addr,
    input wire logic o_mod_addr_valid,
    input wire logic [15:0] o_mod_wdata,
    input wire logic o_mod_data_en,
    input wire logic o_mod_rd,
    input wire logic o_mod_wr
);
    import biu_pkg::*;

    // ==========================================================
    // Common clocking; reset masks every check
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    // Kind of the running cycle seen as a write
    wire write_kind = (o_cycle_kind == KIND_EARLY_WRITE) || (o_cycle_kind == KIND_LATE_WRITE);

    // ==========================================================
    // Register bus and core bus relations
    a_ack_answer: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
        else $error("register bus ack missing");
    a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("register bus ack longer than one cycle");
    a_one_strobe: assert property (!(o_mod_rd && o_mod_wr))
        else $error("read and write strobes together");
    a_strobe_kind: assert property ((o_mod_rd || o_mod_wr) |-> o_mod_wr == write_kind && o_mod_addr_valid)
        else $error("strobe does not match cycle kind");
    a_fast_single: assert property (o_mod_addr_valid && o_cycle_kind == KIND_FAST_READ
        |-> o_mod_rd ##1 !o_mod_addr_valid)
        else $error("fast read not one clock");
    a_late_single: assert property ($rose(o_mod_wr) && o_cycle_kind == KIND_LATE_WRITE |=> !o_mod_wr)
        else $error("late write strobe not one clock");
    a_early_double: assert property ($rose(o_mod_wr) && o_cycle_kind == KIND_EARLY_WRITE
        |=> o_mod_wr ##1 !o_mod_wr)
        else $error("early write strobe not two clocks");
    a_wait_first: assert property ($rose(o_mod_addr_valid) && o_cycle_kind != KIND_FAST_READ
        |-> !o_mod_rd && !o_mod_wr)
        else $error("strobe in address clock");
    a_addr_hold: assert property (o_mod_addr_valid && $past(o_mod_addr_valid) |-> $stable(o_mod_addr))
        else $error("address moved inside a bus cycle");
    a_hold_data: assert property (o_mod_data_en |-> write_kind && o_mod_addr_valid && $stable(o_mod_wdata))
        else $error("write data not held");
    a_hold_end: assert property ($fell(o_mod_wr) && o_mod_addr_valid |-> o_mod_data_en)
        else $error("hold clock without write data");
    a_done_after: assert property (o_cpu_done
        |-> !o_mod_addr_valid && $past(o_mod_addr_valid) && !o_cpu_busy)
        else $error("done not right after bus cycle");

    // ==========================================================
    // Main scenarios reached
    c_fast: cover property (o_cycle_kind == KIND_FAST_READ && o_mod_rd);
    c_early: cover property (o_cycle_kind == KIND_EARLY_WRITE && o_mod_wr);
    c_late: cover property (o_cycle_kind == KIND_LATE_WRITE && o_mod_wr);
endmodule

bind bus_interface_unit biu_chk biu_chk_inst (.i_ref_clk, .i_rst_n, .i_wb_cyc, .i_wb_stb, .o_wb_ack, .o_cpu_busy,
    .o_cpu_done, .o_cycle_kind, .o_mod_addr, .o_mod_addr_valid, .o_mod_wdata, .o_mod_data_en, .o_mod_rd, .o_mod_wr);

/* File: tb/mod_partner.sv */
`timescale 1ns/1ps
module mod_partner (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic [15:0] i_addr,
    input wire logic i_rd,
    input wire logic i_wr,
    input wire logic [15:0] i_wdata,
    output logic [15:0] o_rdata,
    output logic [15:0] o_last_wdata
);
    logic [15:0] prev_rdata;

    // ==========================================================
    // Target answers only under the read strobe; outside it the
    // lines toggle so a stray sample never matches by luck
    wire [15:0] word = i_addr ^ 16'h5A3C;
    assign o_rdata = i_rd ? word : ~prev_rdata;

    // Keep the toggle going and capture each written word
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            prev_rdata <= 16'h0000;
            o_last_wdata <= 16'h0000;
        end else begin
            prev_rdata <= o_rdata;
            if (i_wr) begin
                o_last_wdata <= i_wdata;
            end
        end
    end
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
    import biu_pkg::*;
    logic i_ref_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_wb_cyc = 1'b0, i_wb_stb = 1'b0, i_wb_we = 1'b0;
    logic [15:0] i_wb_adr = 16'h0000;
    logic [31:0] i_wb_dat = 32'h0000_0000;
    logic [3:0] i_wb_sel = 4'h0;
    logic i_cpu_req = 1'b0, i_cpu_we = 1'b0;
    logic [15:0] i_cpu_addr = 16'h0000, i_cpu_wdata = 16'h0000;
    logic [31:0] o_wb_dat;
    logic o_wb_ack, o_cpu_busy, o_cpu_done, o_mod_addr_valid, o_mod_data_en, o_mod_rd, o_mod_wr;
    logic [15:0] o_cpu_rdata, o_mod_addr, o_mod_wdata, mod_rdata, last_wdata;
    cycle_kind_t o_cycle_kind;
    int err_count = 0;
    int tests_run = 0;

    always #2.5 i_ref_clk = ~i_ref_clk;

    bus_interface_unit bus_interface_unit_inst (.i_ref_clk, .i_rst_n, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr,
        .i_wb_dat, .i_wb_sel, .o_wb_dat, .o_wb_ack, .i_cpu_req, .i_cpu_we, .i_cpu_addr, .i_cpu_wdata, .o_cpu_busy,
        .o_cpu_done, .o_cpu_rdata, .o_cycle_kind, .o_mod_addr, .o_mod_addr_valid, .o_mod_wdata, .o_mod_data_en,
        .o_mod_rd, .o_mod_wr, .i_mod_rdata(mod_rdata));

    mod_partner mod_partner_inst (.i_ref_clk, .i_rst_n, .i_addr(o_mod_addr), .i_rd(o_mod_rd), .i_wr(o_mod_wr),
        .i_wdata(o_mod_wdata), .o_rdata(mod_rdata), .o_last_wdata(last_wdata));

    // ==========================================================
    // Reporting
    task automatic end_of_test();
        if (err_count == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic give_up(input string what);
        err_count++;
        $display("CHECK FAILED at %0t: no answer to %s", $time, what);
        end_of_test();
    endtask

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic check_kind(input cycle_kind_t got, input cycle_kind_t exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: cycle kind got %0d expected %0d", $time, got, exp);
        end
    endtask

    // ==========================================================
    // Register bus: ack is looked at mid-cycle; read data is taken and
    // the request released on the very edge that samples ack high
    task automatic wb_access(input logic we, input logic [15:0] adr, input logic [31:0] dat, input logic [3:0] sel,
                             output logic [31:0] rdat);
        int n;
        @(posedge i_ref_clk);
        i_wb_cyc <= 1'b1;
        i_wb_stb <= 1'b1;
        i_wb_we <= we;
        i_wb_adr <= adr;
        i_wb_dat <= dat;
        i_wb_sel <= sel;
        n = 0;
        do begin
            @(negedge i_ref_clk);
            n++;
        end while (o_wb_ack !== 1'b1 && n < 20);
        if (o_wb_ack !== 1'b1) begin
            give_up("register access");
        end else begin
            // Ack stands up to the next edge, where data is taken
            @(posedge i_ref_clk);
            rdat = o_wb_dat;
            i_wb_cyc <= 1'b0;
            i_wb_stb <= 1'b0;
            i_wb_we <= 1'b0;
        end
    endtask

    task automatic wb_write(input logic [15:0] adr, input logic [31:0] dat, input logic [3:0] sel);
        logic [31:0] unused;
        wb_access(1'b1, adr, dat, sel, unused);
    endtask

    task automatic wb_read(input logic [15:0] adr, input logic [31:0] exp);
        logic [31:0] got;
        wb_access(1'b0, adr, 32'h0000_0000, 4'hF, got);
        check_val(got, exp, "register read");
    endtask

    // ==========================================================
    // One CPU transfer: n bus clocks, first strobe clock fs,
    // strobe length sl, hold clocks h
    task automatic cpu_op(input logic we, input logic [15:0] addr, input int n, input cycle_kind_t kind,
                          input int fs, input int sl, input int h);
        int c, first, strobes, den, av, bz;
        logic [15:0] wd;
        wd = ~addr;
        c = 0;
        first = 0;
        strobes = 0;
        den = 0;
        av = 0;
        bz = 0;
        @(posedge i_ref_clk);
        i_cpu_req <= 1'b1;
        i_cpu_we <= we;
        i_cpu_addr <= addr;
        i_cpu_wdata <= wd;
        @(posedge i_ref_clk);
        i_cpu_req <= 1'b0;
        do begin
            @(negedge i_ref_clk);
            c++;
            if ((o_mod_rd || o_mod_wr) && first == 0) begin
                first = c;
            end
            strobes += (o_mod_rd || o_mod_wr);
            den += o_mod_data_en;
            av += o_mod_addr_valid;
            bz += o_cpu_busy;
        end while (o_cpu_done !== 1'b1 && c < 40);
        if (o_cpu_done !== 1'b1) begin
            give_up("cpu transfer");
        end
        check_val(c, n + 1, "done delay");
        check_val(av, n, "bus cycle clocks");
        check_val(bz, n, "busy clocks");
        check_val(o_mod_addr, addr, "bus address");
        check_val(first, fs, "first strobe clock");
        check_val(strobes, sl, "strobe clocks");
        check_val(den, we ? sl + h : 0, "data drive clocks");
        check_kind(o_cycle_kind, kind);
        if (we) begin
            check_val(last_wdata, wd, "written word");
        end else begin
            check_val(o_cpu_rdata, addr ^ 16'h5A3C, "read word");
        end
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (10) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        wb_read(WCC_ADDR, 32'h0000_0007);
        wb_read(ZTC_ADDR, 32'h0000_069F);
        wb_read(16'hF90C, 32'h0000_0000);
        cpu_op(1'b0, 16'h1000, 12, KIND_NORMAL_READ, 9, 1, 3);
        cpu_op(1'b1, 16'h2000, 13, KIND_EARLY_WRITE, 9, 2, 3);
        wb_write(WCC_ADDR, 32'h0000_00FE, 4'h1);
        wb_read(WCC_ADDR, 32'h0000_0006);
        wb_write(ZTC_ADDR, 32'h0000_0691, 4'h3);
        cpu_op(1'b1, 16'h3000, 5, KIND_LATE_WRITE, 3, 1, 2);
        cpu_op(1'b0, 16'h0010, 5, KIND_NORMAL_READ, 3, 1, 2);
        wb_write(ZTC_ADDR, 32'h0000_0680, 4'h3);
        cpu_op(1'b0, 16'hBFFE, 2, KIND_NORMAL_READ, 2, 1, 0);
        cpu_op(1'b1, 16'h0000, 2, KIND_LATE_WRITE, 2, 1, 0);
        wb_write(ZTC_ADDR, 32'h0000_FFFF, 4'h3);
        wb_read(ZTC_ADDR, 32'h0000_0EFF);
        cpu_op(1'b0, 16'h4000, 1, KIND_FAST_READ, 1, 1, 0);
        cpu_op(1'b1, 16'h4002, 2, KIND_LATE_WRITE, 2, 1, 0);
        cpu_op(1'b0, 16'hE000, 2, KIND_NORMAL_READ, 2, 1, 0);
        cpu_op(1'b0, 16'hC000, 2, KIND_NORMAL_READ, 2, 1, 0);
        cpu_op(1'b0, 16'hF100, 3, KIND_NORMAL_READ, 3, 1, 0);
        wb_write(WCC_ADDR, 32'h0000_0007, 4'h1);
        cpu_op(1'b1, 16'hE7FE, 3, KIND_EARLY_WRITE, 2, 2, 0);
        cpu_op(1'b1, 16'hF200, 4, KIND_EARLY_WRITE, 3, 2, 0);
        wb_read(STATUS_ADDR, 32'h0000_0004);
        wb_write(WCC_ADDR, 32'h0000_0006, 4'h1);
        wb_read(WCC_ADDR, 32'h0000_0006);
        end_of_test();
    end
endmodule
